// ---- pic_pkg.sv ----
// Shared constants and types for the prioritized interrupt controller.
// Assumes a single 25 MHz clock and a plain address/strobe register port.
package pic_pkg;

  // ==========================================================================
  // Sizes
  localparam int PIC_NUM_CH   = 64;
  localparam int PIC_NUM_SRC  = 61;
  localparam int PIC_PRIO_W   = 3;
  localparam int PIC_CH_W     = 6;
  localparam int PIC_ADDR_W   = 12;
  localparam int PIC_DATA_W   = 32;
  localparam int PIC_EVT_W    = 2;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [PIC_ADDR_W-1:0] PIC_OFF_SCR_BASE = 12'h000;
  localparam logic [PIC_ADDR_W-1:0] PIC_OFF_PEND_LO  = 12'h100;
  localparam logic [PIC_ADDR_W-1:0] PIC_OFF_PEND_HI  = 12'h104;
  localparam logic [PIC_ADDR_W-1:0] PIC_OFF_EN_LO    = 12'h108;
  localparam logic [PIC_ADDR_W-1:0] PIC_OFF_EN_HI    = 12'h10C;
  localparam logic [PIC_ADDR_W-1:0] PIC_OFF_VECTOR   = 12'h110;
  localparam logic [PIC_ADDR_W-1:0] PIC_OFF_EOS      = 12'h114;
  localparam logic [PIC_ADDR_W-1:0] PIC_OFF_EVT_STAT = 12'h118;
  localparam logic [PIC_ADDR_W-1:0] PIC_OFF_EVT_MASK = 12'h11C;
  localparam logic [PIC_ADDR_W-1:0] PIC_OFF_IN_SERV  = 12'h120;

  // ==========================================================================
  // Field positions
  localparam int PIC_SCR_PRIO_LSB  = 0;
  localparam int PIC_SCR_SENSE_LSB = 3;
  localparam int PIC_VEC_PRIO_LSB  = 8;
  localparam int PIC_VEC_VALID_BIT = 31;
  localparam int PIC_EVT_SPURIOUS  = 0;
  localparam int PIC_EVT_UNDERFLOW = 1;

  // ==========================================================================
  // Types and reset values
  typedef enum logic [1:0] {
    PIC_SENSE_LOW,
    PIC_SENSE_HIGH,
    PIC_SENSE_FALL,
    PIC_SENSE_RISE
  } pic_sense_e;

  localparam logic [PIC_PRIO_W-1:0] PIC_PRIO_RST  = 3'h7;
  localparam pic_sense_e            PIC_SENSE_RST = PIC_SENSE_HIGH;
  localparam logic [3:0]            PIC_NO_LEVEL  = 4'h8;

endpackage

// ---- pic_arbiter.sv ----
// Combinational winner search over all request channels.
// Assumes requests are already masked; threshold comes from the nesting state.
`timescale 1ns/1ps
module pic_arbiter #(
  parameter int NUM_CH = pic_pkg::PIC_NUM_CH
) (
  input  wire logic [NUM_CH-1:0]               i_req,
  input  wire logic [pic_pkg::PIC_PRIO_W-1:0]  i_prio [NUM_CH],
  input  wire logic [3:0]                      i_thresh,
  output logic                                 o_valid,
  output logic [pic_pkg::PIC_CH_W-1:0]         o_ch,
  output logic [pic_pkg::PIC_PRIO_W-1:0]       o_prio
);
  import pic_pkg::*;

  // ==========================================================================
  // Search
  // Descending scan with <= lets the lower channel win a tie
  always_comb begin
    o_valid = 1'b0;
    o_ch    = '0;
    o_prio  = '0;
    for (int c = NUM_CH - 1; c >= 0; c--) begin
      if (i_req[c] && ({1'b0, i_prio[c]} < i_thresh) &&
          (!o_valid || i_prio[c] <= o_prio)) begin
        o_valid = 1'b1;
        o_ch    = PIC_CH_W'(c);
        o_prio  = i_prio[c];
      end
    end
  end

endmodule

// ---- pic_top.sv ----
// Prioritized interrupt controller: sense, pending, masking, nesting, outputs.
// Assumes request inputs are synchronous to i_clk and a one-master register port.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module pic_top #(
  parameter int NUM_CH  = pic_pkg::PIC_NUM_CH,
  parameter int NUM_SRC = pic_pkg::PIC_NUM_SRC
) (
  input  wire logic                            i_clk,
  input  wire logic                            i_reset_n,
  input  wire logic [NUM_CH-1:0]               i_src,
  input  wire logic [pic_pkg::PIC_ADDR_W-1:0]  i_addr,
  input  wire logic [pic_pkg::PIC_DATA_W-1:0]  i_wdata,
  input  wire logic                            i_wr,
  input  wire logic                            i_rd,
  output logic      [pic_pkg::PIC_DATA_W-1:0]  o_rdata,
  output logic                                 o_fast_request_n,
  output logic                                 o_normal_request_n,
  output logic                                 o_irq
);
  import pic_pkg::*;

  // ==========================================================================
  // Decode helpers
  function automatic logic pic_is_scr(input logic [PIC_ADDR_W-1:0] a);
    return (a[PIC_ADDR_W-1:8] == '0) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] pic_lowest_level(input logic [7:0] s);
    logic [3:0] r;
    r = PIC_NO_LEVEL;
    for (int i = 7; i >= 0; i--) begin
      if (s[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // State
  logic [PIC_PRIO_W-1:0]  prio_q   [NUM_CH];
  pic_sense_e             sense_q  [NUM_CH];
  logic [NUM_CH-1:0]      src_q;
  logic [NUM_CH-1:0]      pend_q;
  logic [NUM_CH-1:0]      en_q;
  logic [7:0]             in_serv_q;
  logic [PIC_EVT_W-1:0]   evt_stat_q;
  logic [PIC_EVT_W-1:0]   evt_mask_q;
  logic                   win_valid_q;
  logic [PIC_CH_W-1:0]    win_ch_q;
  logic [PIC_PRIO_W-1:0]  win_prio_q;

  logic                   arb_valid;
  logic [PIC_CH_W-1:0]    arb_ch;
  logic [PIC_PRIO_W-1:0]  arb_prio;
  logic [3:0]             thresh;
  logic [NUM_CH-1:0]      edge_hit;
  logic                   scr_wr;
  logic                   vec_rd;
  logic                   vec_ack;
  logic                   eos_wr;
  logic [PIC_EVT_W-1:0]   evt_set;

  assign scr_wr  = i_wr && pic_is_scr(i_addr);
  assign vec_rd  = i_rd && (i_addr == PIC_OFF_VECTOR);
  assign vec_ack = vec_rd && win_valid_q;
  assign eos_wr  = i_wr && (i_addr == PIC_OFF_EOS);
  assign thresh  = pic_lowest_level(in_serv_q);

  assign evt_set[PIC_EVT_SPURIOUS]  = vec_rd && !win_valid_q;
  assign evt_set[PIC_EVT_UNDERFLOW] = eos_wr && (in_serv_q == 8'h00);

  // ==========================================================================
  // Source configuration
  // Reset sense is high level, matching on-chip request lines
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        prio_q[c]  <= PIC_PRIO_RST;
        sense_q[c] <= PIC_SENSE_RST;
      end
    end else if (scr_wr) begin
      prio_q[i_addr[7:2]]  <= i_wdata[PIC_SCR_PRIO_LSB +: PIC_PRIO_W];
      sense_q[i_addr[7:2]] <= pic_sense_e'(i_wdata[PIC_SCR_SENSE_LSB +: 2]);
    end
  end

  // ==========================================================================
  // Enables
  // Whole-word writes only: software must read-modify-write single bits
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_q <= '0;
    end else if (i_wr && i_addr == PIC_OFF_EN_LO) begin
      en_q[31:0] <= i_wdata;
    end else if (i_wr && i_addr == PIC_OFF_EN_HI) begin
      en_q[NUM_CH-1:32] <= i_wdata[NUM_CH-33:0];
    end
  end

  // ==========================================================================
  // Sensing and pending flags
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      src_q <= '0;
    end else begin
      src_q <= i_src;
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      case (sense_q[c])
        PIC_SENSE_FALL: edge_hit[c] = src_q[c] && !i_src[c];
        PIC_SENSE_RISE: edge_hit[c] = !src_q[c] && i_src[c];
        default:        edge_hit[c] = 1'b0;
      endcase
    end
  end

  // Edge flags: a new edge in the acknowledge cycle keeps the flag set
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_q <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (c >= NUM_SRC) begin
          pend_q[c] <= 1'b0;
        end else begin
          case (sense_q[c])
            PIC_SENSE_LOW:  pend_q[c] <= !i_src[c];
            PIC_SENSE_HIGH: pend_q[c] <= i_src[c];
            default: begin
              if (edge_hit[c]) begin
                pend_q[c] <= 1'b1;
              end else if (vec_ack && win_ch_q == PIC_CH_W'(c)) begin
                pend_q[c] <= 1'b0;
              end
            end
          endcase
        end
      end
    end
  end

  // ==========================================================================
  // Arbitration
  // Winner is registered so the long search chain never reaches a pin
  pic_arbiter #(
    .NUM_CH   (NUM_CH)
  ) u_arbiter (
    .i_req    (pend_q & en_q),
    .i_prio   (prio_q),
    .i_thresh (thresh),
    .o_valid  (arb_valid),
    .o_ch     (arb_ch),
    .o_prio   (arb_prio)
  );

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      win_valid_q <= 1'b0;
      win_ch_q    <= '0;
      win_prio_q  <= '0;
    end else begin
      win_valid_q <= arb_valid;
      win_ch_q    <= arb_ch;
      win_prio_q  <= arb_prio;
    end
  end

  // ==========================================================================
  // Processor request lines
  // Level 0 is below every in-service level except level 0 itself, so it preempts them
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_fast_request_n   <= 1'b1;
      o_normal_request_n <= 1'b1;
    end else begin
      o_fast_request_n   <= !(win_valid_q && win_prio_q == '0);
      o_normal_request_n <= !(win_valid_q && win_prio_q != '0);
    end
  end

  // ==========================================================================
  // Nesting
  // Acknowledge pushes the winner's level; end of service pops the most urgent
  // One slot per level: a level cannot nest on itself
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      in_serv_q <= 8'h00;
    end else if (vec_ack) begin
      in_serv_q[win_prio_q] <= 1'b1;
    end else if (eos_wr && thresh != PIC_NO_LEVEL) begin
      in_serv_q[thresh[2:0]] <= 1'b0;
    end
  end

  // ==========================================================================
  // Event status, mask and interrupt
  // A set in the clearing read cycle wins, so no event is lost
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      evt_stat_q <= '0;
    end else if (i_rd && i_addr == PIC_OFF_EVT_STAT) begin
      evt_stat_q <= evt_set;
    end else begin
      evt_stat_q <= evt_stat_q | evt_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      evt_mask_q <= '0;
    end else if (i_wr && i_addr == PIC_OFF_EVT_MASK) begin
      evt_mask_q <= i_wdata[PIC_EVT_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |((evt_stat_q | evt_set) & evt_mask_q);
    end
  end

  // ==========================================================================
  // Read port
  // Data stands only in the cycle after the strobe; unmapped reads return zero
  // Reading the vector is the acknowledge, so a stray read acks too whenever a winner is valid
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
    end else if (!i_rd) begin
      o_rdata <= '0;
    end else if (pic_is_scr(i_addr)) begin
      o_rdata <= {27'h000_0000, 2'(sense_q[i_addr[7:2]]), prio_q[i_addr[7:2]]};
    end else begin
      case (i_addr)
        PIC_OFF_PEND_LO:  o_rdata <= pend_q[31:0];
        PIC_OFF_PEND_HI:  o_rdata <= pend_q[NUM_CH-1:32];
        PIC_OFF_EN_LO:    o_rdata <= en_q[31:0];
        PIC_OFF_EN_HI:    o_rdata <= en_q[NUM_CH-1:32];
        PIC_OFF_VECTOR:   o_rdata <= {win_valid_q, 20'h0_0000, win_prio_q, 2'h0, win_ch_q};
        PIC_OFF_EVT_STAT: o_rdata <= {30'h0000_0000, evt_stat_q};
        PIC_OFF_EVT_MASK: o_rdata <= {30'h0000_0000, evt_mask_q};
        PIC_OFF_IN_SERV:  o_rdata <= {24'h00_0000, in_serv_q};
        default:          o_rdata <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_fast_from_zero: assert property (
    win_valid_q && win_prio_q == '0 |=> !o_fast_request_n && o_normal_request_n)
    else $error("fast request missing for level 0 winner");

  a_normal_from_rest: assert property (
    win_valid_q && win_prio_q != '0 |=> !o_normal_request_n && o_fast_request_n)
    else $error("normal request missing for level 1-7 winner");

  a_idle_lines_high: assert property (
    !win_valid_q |=> o_fast_request_n && o_normal_request_n)
    else $error("request line low with no winner");

  a_spare_quiet: assert property (
    pend_q[NUM_CH-1:NUM_SRC] == '0)
    else $error("undefined channel pending");

  a_masked_silent: assert property (
    (pend_q & en_q) == '0 |=> !win_valid_q)
    else $error("winner without enabled pending source");

  a_nest_blocks: assert property (
    win_valid_q |-> {1'b0, win_prio_q} < $past(thresh))
    else $error("winner not above in-service level");

  a_ack_nests: assert property (
    vec_ack |=> in_serv_q[$past(win_prio_q)])
    else $error("acknowledge did not mark level in service");

  a_edge_clears: assert property (
    vec_ack && sense_q[win_ch_q] == PIC_SENSE_RISE && !edge_hit[win_ch_q] && !scr_wr
    |=> !pend_q[$past(win_ch_q)])
    else $error("edge pending flag not cleared on acknowledge");

  a_high_level: assert property (
    sense_q[0] == PIC_SENSE_HIGH && i_src[0] |=> pend_q[0])
    else $error("high level source not pending");

  a_rdata_slot: assert property (
    !i_rd |=> o_rdata == '0)
    else $error("read data outside its slot");

  a_eos_pops: assert property (
    eos_wr && thresh != PIC_NO_LEVEL |=> thresh > $past(thresh))
    else $error("end of service did not release a level");

  a_evt_sticky: assert property (
    evt_set != '0 |=> (evt_stat_q & $past(evt_set)) == $past(evt_set))
    else $error("event not held in status");

  a_irq_masked: assert property (
    evt_mask_q == '0 |=> !o_irq)
    else $error("interrupt raised with all events masked");

  a_pend_readback: assert property (
    i_rd && i_addr == PIC_OFF_PEND_LO |=>
    {32'h0000_0000, o_rdata} == ($past(pend_q) & 64'h0000_0000_FFFF_FFFF))
    else $error("pending word read back wrong");

  a_spurious_flag: assert property (
    vec_rd && !win_valid_q |=> evt_stat_q[PIC_EVT_SPURIOUS])
    else $error("spurious acknowledge not flagged");

  c_fast_request:  cover property (!o_fast_request_n);
  c_nested_two:    cover property ($countones(in_serv_q) == 2);
  c_fast_preempts: cover property (in_serv_q != 8'h00 && !in_serv_q[0] ##1 !o_fast_request_n);
  c_spurious:      cover property (evt_set[PIC_EVT_SPURIOUS]);
  c_edge_ack:      cover property (vec_ack && sense_q[win_ch_q] == PIC_SENSE_RISE);

endmodule

// ---- pic_far_model.sv ----
// Far-side model: peripheral request lines feeding the controller.
// Assumes the bench supplies the wanted request level of every channel.
`timescale 1ns/1ps
module pic_far_model (
  input  wire logic [63:0] i_level,
  output logic      [63:0] o_src
);
  // ======================================
  // Request lines
  // Plain held levels, no pulses; spare channels are driven too on purpose
  assign o_src = i_level;
endmodule

// ---- prioritized_interrupt_controller_tb_top.sv ----
// Bench: random arbitration with nesting, sense modes and events against a model.
// Assumes pic_pkg, pic_top and pic_far_model; one 25 MHz clock.
`timescale 1ns/1ps
module prioritized_interrupt_controller_tb_top;
  import pic_pkg::*;
  logic        i_clk, i_reset_n, i_wr, i_rd, o_irq;
  logic        o_fast_request_n, o_normal_request_n;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rv, seed;
  logic [63:0] line, i_src, pend, en;
  int          err_count, checked, inserv, evt, w, s;
  int          prio [64];
  int          sen [4] = '{1, 3, 0, 2};

  pic_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_src(i_src), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_fast_request_n(o_fast_request_n), .o_normal_request_n(o_normal_request_n));
  pic_far_model far (.i_level(line), .o_src(i_src));

  // ======================================
  // Clock and helpers
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Settle past the edge so outputs are read after their update
  task automatic tick(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(logic [11:0] a);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask

  task automatic cmp_word(logic [31:0] g, logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmp_pin(logic g, logic e);
    cmp_word({31'h0, g}, {31'h0, e});
  endtask

  // ======================================
  // Model: winner below the most urgent level in service
  function automatic int win();
    int top;
    int best;
    top  = 8;
    best = -1;
    for (int l = 7; l >= 0; l--)
      if (inserv[l])
        top = l;
    for (int c = PIC_NUM_SRC - 1; c >= 0; c--)
      if (pend[c] && en[c] && prio[c] < top && (best < 0 || prio[c] <= prio[best]))
        best = c;
    return best;
  endfunction

  task automatic check_out();
    w = win();
    cmp_pin(o_fast_request_n, !(w >= 0 && prio[w] == 0));
    cmp_pin(o_normal_request_n, !(w >= 0 && prio[w] != 0));
  endtask

  task automatic ack();
    w = win();
    rd(PIC_OFF_VECTOR);
    cmp_word(rv, w < 0 ? 32'h0 : 32'h8000_0000 + 32'(prio[w] * 256 + w));
    if (w < 0)
      evt |= 1;
    else
      inserv |= 1 << prio[w];
  endtask

  // EOS pops the most urgent level, i.e. the lowest set bit
  task automatic eos();
    wr(PIC_OFF_EOS, 32'h0);
    if (inserv == 0)
      evt |= 2;
    inserv &= inserv - 1;
  endtask

  task automatic chk_evt();
    tick(1);
    cmp_pin(o_irq, evt != 0);
    rd(PIC_OFF_EVT_STAT);
    cmp_word(rv, 32'(evt));
    evt = 0;
    tick(2);
    cmp_pin(o_irq, 1'b0);
  endtask

  // Channel 9 level change under sense s; edge flags are sticky
  task automatic set9(logic v);
    @(posedge i_clk);
    line[9] <= v;
    if (s < 2)
      pend[9] = (v == s[0]);
    else if (v == s[0])
      pend[9] = 1'b1;
    tick(4);
    rd(PIC_OFF_PEND_LO);
    cmp_word(rv, pend[31:0]);
    check_out();
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ======================================
  // Watchdog
  initial begin
    #(40 * 30000);
    err_count++;
    report_and_stop();
  end

  // ======================================
  // Main sequence
  initial begin
    i_reset_n = 1'b0;
    i_wr      = 1'b0;
    i_rd      = 1'b0;
    i_addr    = 12'h000;
    i_wdata   = 32'h0;
    seed      = 32'h0000_0020;
    line      = 64'h4000_0000_0000_0000;
    pend      = line;
    en        = 64'hFFFF_FFFF_0000_0000;
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    tick(1);
    cmp_pin(o_fast_request_n, 1'b1);
    cmp_pin(o_normal_request_n, 1'b1);
    cmp_pin(o_irq, 1'b0);
    rd(PIC_OFF_SCR_BASE + 12'h014);
    cmp_word(rv, 32'h0000_000F);
    rd(12'h200);
    cmp_word(rv, 32'h0);
    $display("test reset done");
    for (int c = 0; c < 64; c++) begin
      prio[c] = (c == 8 || c == 62) ? 0 : 7;
      wr(PIC_OFF_SCR_BASE + 12'(4 * c), 32'(8 + prio[c]));
    end
    wr(PIC_OFF_EN_HI, 32'hFFFF_FFFF);
    rd(PIC_OFF_PEND_HI);
    cmp_word(rv, pend[63:32] & 32'h1FFF_FFFF);
    ack();
    tick(2);
    cmp_pin(o_irq, 1'b0);
    wr(PIC_OFF_EVT_MASK, 32'h0000_0003);
    chk_evt();
    $display("test events done");
    for (int n = 0; n < 24; n++) begin
      for (int c = 0; c < 8; c++) begin
        prio[c] = int'(rnd() % 8);
        wr(PIC_OFF_SCR_BASE + 12'(4 * c), 32'(8 + prio[c]));
      end
      en[31:0] = rnd();
      wr(PIC_OFF_EN_LO, en[31:0]);
      @(posedge i_clk);
      rv = rnd();
      line[7:0] <= rv[7:0];
      pend[7:0] = rv[7:0];
      tick(4);
      rd(PIC_OFF_PEND_LO);
      cmp_word(rv, pend[31:0]);
      for (int k = 0; k < 4; k++) begin
        if (k == 1) begin
          @(posedge i_clk);
          line[8] <= 1'b1;
          pend[8] = 1'b1;
          tick(4);
        end
        check_out();
        ack();
        tick(4);
      end
      rd(PIC_OFF_IN_SERV);
      cmp_word(rv, 32'(inserv));
      repeat (4) begin
        eos();
        tick(4);
        check_out();
      end
      chk_evt();
      @(posedge i_clk);
      line[8:0] <= 9'h000;
      pend[8:0] = 9'h000;
    end
    $display("test arbitration done");
    wr(PIC_OFF_EN_LO, 32'h0000_0200);
    en[31:0] = 32'h0000_0200;
    prio[9] = 1;
    foreach (sen[i]) begin
      s = sen[i];
      wr(PIC_OFF_SCR_BASE + 12'h024, 32'(s * 8 + 1));
      set9(!s[0]);
      set9(s[0]);
      set9(!s[0]);
      ack();
      if (s >= 2)
        pend[9] = 1'b0;
      set9(!s[0]);
      eos();
      chk_evt();
    end
    $display("test sense done");
    report_and_stop();
  end
endmodule
